// File: tcic_pkg.sv
// Constants shared by the three-channel input capture block.
// Assumes a single 10 MHz clock, one cycle per instruction cycle.
package tcic_pkg;
	// ************************************************************
	// Register map (byte addresses, one word each)
	// ************************************************************
	localparam logic [7:0] OFF_CTRL1 = 8'h00;
	localparam logic [7:0] OFF_CTRL2 = 8'h04;
	localparam logic [7:0] OFF_CTRL3 = 8'h08;
	localparam logic [7:0] OFF_BUF1 = 8'h0C;
	localparam logic [7:0] OFF_BUF2 = 8'h10;
	localparam logic [7:0] OFF_BUF3 = 8'h14;
	localparam logic [7:0] OFF_TIMER = 8'h18;
	localparam logic [7:0] OFF_FLAGS = 8'h1C;
	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int CTRL_REN_BIT = 6;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [15:0] TIMER_STEP = 16'h0001;
	localparam int NUM_CH = 3;
	// ************************************************************
	// Mode codes
	// ************************************************************
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_FALL = 4'h1;
	localparam logic [3:0] MODE_RISE = 4'h2;
	localparam logic [3:0] MODE_RISE4 = 4'h3;
	localparam logic [3:0] MODE_RISE16 = 4'h4;
	localparam logic [3:0] MODE_PERIOD = 4'h5;
	localparam logic [3:0] MODE_PW_FR = 4'h6;
	localparam logic [3:0] MODE_PW_RF = 4'h7;
	localparam logic [3:0] MODE_CHANGE = 4'h8;
	localparam logic [3:0] MODE_TRIG_F = 4'hE;
	localparam logic [3:0] MODE_TRIG_R = 4'hF;
	// Prescaler terminal counts for every 4th and 16th rising edge
	localparam logic [3:0] PRE_LAST4 = 4'h3;
	localparam logic [3:0] PRE_LAST16 = 4'hF;
	localparam logic [3:0] PRE_STEP = 4'h1;
	localparam logic [3:0] PRE_CLEAR = 4'h0;
endpackage : tcic_pkg

// File: tcic_chan_if.sv
// Interface between the capture top and one channel decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface tcic_chan_if;
	logic [3:0] mode;
	logic ren;
	logic mode_wr;
	logic enable;
	logic rise;
	logic fall;
	logic cap;
	logic rst;
	logic trig;
	modport top (output mode, ren, mode_wr, enable, rise, fall,
		input cap, rst, trig);
	modport chan (input mode, ren, mode_wr, enable, rise, fall,
		output cap, rst, trig);
endinterface : tcic_chan_if
`default_nettype wire

// File: tcic_channel.sv
// One capture channel: mode decode, prescaler and pulse sequencing.
// Assumes synchronised, one-cycle edge pulses from the top.
`timescale 1ns/1ns
`default_nettype none
module tcic_channel
	import tcic_pkg::*;
#(
	parameter bit HAS_TRIG = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	tcic_chan_if.chan ch
);
	typedef enum logic [1:0] {
		ST_FIRST = 2'b00,
		ST_WAIT = 2'b01,
		ST_MEAS = 2'b11
	} tcic_pw_t;
	tcic_pw_t st_r, st_nxt;
	logic [3:0] pre_r, pre_nxt;
	logic hit, start, stop, first;
	assign first = (st_r == ST_FIRST);
	// ************************************************************
	// Edge qualification
	// ************************************************************
	always_comb begin
		hit = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		ch.trig = 1'b0;
		case (ch.mode)
			MODE_FALL: hit = ch.fall;
			MODE_RISE: hit = ch.rise;
			MODE_RISE4: hit = ch.rise & (first | pre_r == PRE_LAST4);
			MODE_RISE16: hit = ch.rise & (first | pre_r == PRE_LAST16);
			MODE_PERIOD: hit = ch.rise;
			MODE_PW_RF: begin
				start = ch.rise;
				stop = ch.fall;
			end
			MODE_PW_FR: begin
				start = ch.fall;
				stop = ch.rise;
			end
			MODE_CHANGE: hit = ch.rise | ch.fall;
			MODE_TRIG_R: ch.trig = HAS_TRIG & ch.rise & ch.enable;
			MODE_TRIG_F: ch.trig = HAS_TRIG & ch.fall & ch.enable;
			default: hit = 1'b0;
		endcase
	end
	always_comb begin
		ch.cap = 1'b0;
		ch.rst = 1'b0;
		st_nxt = st_r;
		if (ch.mode_wr) begin
			st_nxt = ST_FIRST;
		end else if (ch.enable && (start || stop)) begin
			// First edge in pulse mode is always captured and restarts
			if (first) begin
				ch.cap = 1'b1;
				ch.rst = 1'b1;
				st_nxt = start ? ST_MEAS : ST_WAIT;
			end else if (start) begin
				ch.rst = 1'b1;
				st_nxt = ST_MEAS;
			end else if (st_r == ST_MEAS) begin
				ch.cap = 1'b1;
				st_nxt = ST_WAIT;
			end
		end else if (ch.enable && hit) begin
			ch.cap = 1'b1;
			ch.rst = ch.ren;
			st_nxt = ST_WAIT;
		end
	end
	// ************************************************************
	// Prescaler
	// ************************************************************
	always_comb begin
		pre_nxt = pre_r;
		if (ch.mode == MODE_OFF) begin
			pre_nxt = PRE_CLEAR;
		end else if (ch.enable && ch.rise &&
			(ch.mode == MODE_RISE4 || ch.mode == MODE_RISE16)) begin
			pre_nxt = hit ? PRE_CLEAR : 4'(pre_r + PRE_STEP);
		end
	end
	// A direct change between active modes leaves the count alone
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pre_r <= PRE_CLEAR;
		end else begin
			pre_r <= pre_nxt;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= ST_FIRST;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : tcic_channel
`default_nettype wire

// File: tcic_capture.sv
// Three-channel input capture on a shared 16-bit time base.
// Assumes synchronous pin inputs and a one-cycle strobe register port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Quadrature decoder active blocks all capture action
// - Three channels, each with 16-bit buffer
// - Channel one trigger on rise or fall
// - Codes 1001-1101 unused; triggers unused elsewhere
// - Control: reset enable bit 6, mode 3:0
// - Mode 1000 captures every pin change
// - Modes 0111, 0110 select pulse-width measurement
// - Period mode captures rising, optional timer clear
// - Falling, rising, 4th and 16th rising
// - Mode 0000 turns the channel off
// - Writing off clears the prescaler
// - Active to active change keeps prescaler
// - Synchronise pin, then load buffer next
// - Timer cleared after capture when enabled
// - First edge after mode write always captures
// - Software timer write beats capture reset
// - Buffer takes the already incremented timer
// - Channel one trigger starts analog conversion
// - Flag set in modes 0001 to 1000
// - No channel one flag in trigger modes
// - Pulse modes reset timer ignoring enable bit
// - Reset on starting edge, capture opposite edge
module tcic_capture
	import tcic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic capture_pin_one,
	input wire logic capture_pin_two,
	input wire logic capture_pin_three,
	input wire logic quadrature_decoder_active,
	output logic adc_start_trigger,
	output logic [2:0] capture_flags,
	output logic [15:0] time_base_count
);
	// ************************************************************
	// Address decode helpers
	// ************************************************************
	// Returns one-hot select of a control register at an address
	function automatic logic [2:0] ctrl_sel(input logic [7:0] a);
		logic [2:0] s;
		s = 3'h0;
		case (a)
			OFF_CTRL1: s = 3'h1;
			OFF_CTRL2: s = 3'h2;
			OFF_CTRL3: s = 3'h4;
			default: s = 3'h0;
		endcase
		return s;
	endfunction : ctrl_sel

	// Returns one-hot select of a capture buffer at an address
	function automatic logic [2:0] buf_sel(input logic [7:0] a);
		logic [2:0] s;
		s = 3'h0;
		case (a)
			OFF_BUF1: s = 3'h1;
			OFF_BUF2: s = 3'h2;
			OFF_BUF3: s = 3'h4;
			default: s = 3'h0;
		endcase
		return s;
	endfunction : buf_sel

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0] ctrl_r [NUM_CH];
	logic [15:0] capture_buffer_r [NUM_CH];
	logic [15:0] count_r, count_nxt;
	logic [2:0] flag_r, flag_nxt;
	logic [2:0] sync1_r, sync2_r, prev_r;
	logic [2:0] pin_v, rise_v, fall_v;
	logic [2:0] cap_v, rst_v, wr_ctrl_v, flag_mode_v;
	logic [2:0] rd_ctrl_v, rd_buf_v;
	logic [2:0] trig_v;
	logic [31:0] rdata_r, rdata_nxt;
	logic trig_r;
	logic timer_wr;
	logic [15:0] count_inc;
	logic capture_enable;

	assign pin_v = {capture_pin_three, capture_pin_two, capture_pin_one};
	assign timer_wr = reg_wr && (reg_addr == OFF_TIMER);
	assign wr_ctrl_v = reg_wr ? ctrl_sel(reg_addr) : 3'h0;
	assign rd_ctrl_v = ctrl_sel(reg_addr);
	assign rd_buf_v = buf_sel(reg_addr);
	// Pins are shared with the quadrature decoder, which wins
	assign capture_enable = !quadrature_decoder_active;

	// ************************************************************
	// Pin synchronisers and edge detect
	// ************************************************************
	// Only the second stage is looked at, never the first
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			prev_r <= 3'h0;
		end else begin
			sync1_r <= pin_v;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign rise_v = sync2_r & ~prev_r;
	assign fall_v = ~sync2_r & prev_r;

	// ************************************************************
	// Channel decoders
	// ************************************************************
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		tcic_chan_if ch_if ();
		assign ch_if.mode = ctrl_r[i][CTRL_MODE_LSB +: CTRL_MODE_W];
		assign ch_if.ren = ctrl_r[i][CTRL_REN_BIT];
		assign ch_if.mode_wr = wr_ctrl_v[i];
		assign ch_if.enable = capture_enable;
		assign ch_if.rise = rise_v[i];
		assign ch_if.fall = fall_v[i];
		assign cap_v[i] = ch_if.cap;
		assign rst_v[i] = ch_if.rst;
		assign trig_v[i] = ch_if.trig;
		// Only capture modes raise the flag, never trigger modes
		assign flag_mode_v[i] = (ch_if.mode >= MODE_FALL) &&
			(ch_if.mode <= MODE_CHANGE);
		tcic_channel #(
			.HAS_TRIG(i == 0)
		) u_chan (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.ch(ch_if.chan)
		);
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	// Writes land directly; no mode change protection in hardware
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_r[i] <= CTRL_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (wr_ctrl_v[i]) begin
					ctrl_r[i] <= {1'b0, reg_wdata[CTRL_REN_BIT], 2'b00,
						reg_wdata[CTRL_MODE_LSB +: CTRL_MODE_W]};
				end
			end
		end
	end

	// ************************************************************
	// Time base timer
	// ************************************************************
	assign count_inc = 16'(count_r + TIMER_STEP);

	// Several channel resets in one cycle act as one clear
	always_comb begin
		if (timer_wr) begin
			count_nxt = reg_wdata[15:0];
		end else if (|rst_v) begin
			count_nxt = TIMER_RESET;
		end else begin
			count_nxt = count_inc;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count_r <= TIMER_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end
	assign time_base_count = count_r;

	// ************************************************************
	// Capture buffers
	// ************************************************************
	// The buffer sees the timer plus one, even when the timer clears or is written
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				capture_buffer_r[i] <= TIMER_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (cap_v[i]) begin
					capture_buffer_r[i] <= count_inc;
				end
			end
		end
	end

	// ************************************************************
	// Capture flags
	// ************************************************************
	// Write one to clear; a capture in the same cycle wins
	always_comb begin
		flag_nxt = flag_r;
		if (reg_wr && reg_addr == OFF_FLAGS) begin
			flag_nxt = flag_r & ~reg_wdata[2:0];
		end
		flag_nxt = flag_nxt | (cap_v & flag_mode_v);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flag_r <= 3'h0;
		end else begin
			flag_r <= flag_nxt;
		end
	end
	assign capture_flags = flag_r;

	// ************************************************************
	// Special event trigger
	// ************************************************************
	// One-cycle pulse toward the converter, channel one only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			trig_r <= 1'b0;
		end else begin
			trig_r <= trig_v[0];
		end
	end
	assign adc_start_trigger = trig_r;

	// ************************************************************
	// Register read port
	// ************************************************************
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (rd_ctrl_v[i]) begin
					rdata_nxt = {24'h00_0000, ctrl_r[i]};
				end
				if (rd_buf_v[i]) begin
					rdata_nxt = {16'h0000, capture_buffer_r[i]};
				end
			end
			if (reg_addr == OFF_TIMER) begin
				rdata_nxt = {16'h0000, count_r};
			end
			if (reg_addr == OFF_FLAGS) begin
				rdata_nxt = {29'h0000_0000, flag_r};
			end
		end
	end

	// Data stands for exactly one cycle after the read strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;
endmodule : tcic_capture
`default_nettype wire

// File: tcic_checker.sv
// Port-level assertions for the three-channel capture block.
// Assumes one clock, synchronous active-low reset and the package map.
`timescale 1ns/1ns
`default_nettype none
module tcic_checker
	import tcic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic capture_pin_one,
	input wire logic capture_pin_two,
	input wire logic capture_pin_three,
	input wire logic quadrature_decoder_active,
	input wire logic adc_start_trigger,
	input wire logic [2:0] capture_flags,
	input wire logic [15:0] time_base_count
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic [2:0] pins = {capture_pin_three, capture_pin_two, capture_pin_one};
	wire logic tmr_wr = reg_wr && reg_addr == OFF_TIMER;
	wire logic flg_wr = reg_wr && reg_addr == OFF_FLAGS;
	wire logic [15:0] wr_val = reg_wdata[15:0];
	// Pin edges need three edges to reach the buffers
	timer_step_a: assert property ($past(rst_n) && !$past(tmr_wr) |->
		time_base_count == $past(time_base_count) + TIMER_STEP
		|| time_base_count == TIMER_RESET) else $error("timer jumped");
	timer_write_a: assert property ($past(rst_n) && $past(tmr_wr) |->
		time_base_count == $past(wr_val)) else $error("timer write lost");
	timer_clear_a: assert property (time_base_count == TIMER_RESET
		&& $past(rst_n) && !$past(tmr_wr) && $past(time_base_count) != 16'hFFFF
		|-> $past(pins, 3) != $past(pins, 4)) else $error("timer cleared");
	ctrl_read_a: assert property ($past(reg_rd) && $past(reg_addr) <= OFF_CTRL3
		|-> reg_rdata[31:7] == 25'h0 && reg_rdata[5:4] == 2'h0)
		else $error("reserved control bits set");
	timer_read_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_TIMER
		|-> reg_rdata == {16'h0000, $past(time_base_count)}) else $error("timer read");
	qdec_block_a: assert property ($past(quadrature_decoder_active) |->
		!adc_start_trigger && (capture_flags & ~$past(capture_flags)) == 3'h0)
		else $error("capture while decoder owns pins");
	flag_cause_a: assert property ($rose(capture_flags[0]) |->
		$past(capture_pin_one, 3) != $past(capture_pin_one, 4)) else $error("flag");
	trig_cause_a: assert property (adc_start_trigger |-> !$rose(capture_flags[0])
		&& $past(capture_pin_one, 3) != $past(capture_pin_one, 4))
		else $error("trigger without pin edge");
	flag_sticky_a: assert property ($past(rst_n) &&
		|($past(capture_flags) & ~capture_flags) |-> $past(flg_wr))
		else $error("flag dropped");
	trig_c: cover property (adc_start_trigger);
	flag_c: cover property ($rose(capture_flags[0]));
	clear_c: cover property ($past(rst_n) && time_base_count == TIMER_RESET);
endmodule : tcic_checker
bind tcic_capture tcic_checker tcic_checker_i (.sys_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .capture_pin_one, .capture_pin_two,
	.capture_pin_three, .quadrature_decoder_active, .adc_start_trigger,
	.capture_flags, .time_base_count);
`default_nettype wire

// File: tcic_pin_src.sv
// Pulse source standing on the three capture pins.
// Assumes callers start right after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module tcic_pin_src (
	input wire logic sys_clk,
	output logic [2:0] pins
);
	initial pins = 3'h0;
	// Each level is held two cycles, as many as the two-stage synchroniser needs to pass it
	task automatic drive(input int ch, input logic lvl);
		pins[ch] <= lvl;
		repeat (2) @(posedge sys_clk);
	endtask : drive
endmodule : tcic_pin_src
`default_nettype wire

// File: tcic_capture_tb.sv
// Self-checking bench for the three-channel capture block.
// Assumes the pin source model and the package register map.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) begin \
			n_mismatch++; \
			$display("[FAIL] %0t got %h expected %h", $time, (g), (e)); \
		end \
	end
module tcic_capture_tb
	import tcic_pkg::*;
;
	typedef struct {int ch; logic [7:0] ctl; logic q; int n;
		logic [63:0] cap; logic [63:0] clr; int tr;} tcic_case_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic qdec_on = 1'b0;
	wire logic [31:0] reg_rdata;
	wire logic [2:0] pins;
	wire logic trig;
	wire logic [2:0] flags;
	wire logic [15:0] tmr;
	int n_mismatch = 0;
	int check_count = 0;
	int trig_count = 0;
	int exp_trig = 0;
	logic [15:0] v = 16'h0100;
	logic [15:0] expbuf [3] = '{default: 16'h0};
	logic [2:0] lvl = 3'h0;
	// Each mode's edge walk; bit k of cap and clr belongs to edge k
	tcic_case_t tab [17] = '{
		'{0, 8'h02, 1'b0, 3, 64'h5, 64'h0, 0}, '{0, 8'h41, 1'b0, 3, 64'h5, 64'h5, 0},
		'{0, 8'h45, 1'b0, 3, 64'h5, 64'h5, 0}, '{0, 8'h08, 1'b0, 3, 64'h7, 64'h0, 0},
		'{0, 8'h07, 1'b0, 4, 64'hB, 64'h5, 0}, '{0, 8'h06, 1'b0, 3, 64'h5, 64'h3, 0},
		'{0, 8'h03, 1'b0, 10, 64'h202, 64'h0, 0},
		'{0, 8'h04, 1'b0, 34, 64'h200000002, 64'h0, 0},
		'{0, 8'h4F, 1'b0, 2, 64'h0, 64'h0, 1}, '{0, 8'h4E, 1'b0, 2, 64'h0, 64'h0, 1},
		'{0, 8'h4D, 1'b0, 2, 64'h0, 64'h0, 0}, '{0, 8'h00, 1'b0, 2, 64'h0, 64'h0, 0},
		'{0, 8'h08, 1'b1, 2, 64'h0, 64'h0, 0}, '{1, 8'h4F, 1'b0, 2, 64'h0, 64'h0, 0},
		'{1, 8'h02, 1'b0, 2, 64'h1, 64'h0, 0}, '{2, 8'h49, 1'b0, 2, 64'h0, 64'h0, 0},
		'{2, 8'h42, 1'b0, 2, 64'h1, 64'h1, 0}};
	tcic_capture tcic_capture_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .capture_pin_one(pins[0]), .capture_pin_two(pins[1]),
		.capture_pin_three(pins[2]), .quadrature_decoder_active(qdec_on),
		.adc_start_trigger(trig), .capture_flags(flags), .time_base_count(tmr));
	tcic_pin_src tcic_pin_src_i (.sys_clk, .pins);
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (trig === 1'b1) trig_count++;
	end
	task automatic results;
		if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	// Write strobe stays up so writes can run back to back; idle drops it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
	endtask : wr
	task automatic idle;
		reg_wr <= 1'b0;
	endtask : idle
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_wr <= 1'b0;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
		@(posedge sys_clk);
	endtask : rd
	// Timer loaded at the pin edge, so the buffer must show v plus three
	task automatic step(input int ch, input logic c, input logic z);
		lvl[ch] = ~lvl[ch];
		wr(OFF_FLAGS, 32'h7);
		wr(OFF_TIMER, {16'h0, v});
		idle();
		tcic_pin_src_i.drive(ch, lvl[ch]);
		@(posedge sys_clk);
		if (c) expbuf[ch] = v + 16'h3;
		rd(OFF_FLAGS, {29'h0, c ? 3'b001 << ch : 3'b000});
		rd(OFF_BUF1 + 8'(4 * ch), {16'h0, expbuf[ch]});
		rd(OFF_TIMER, {16'h0, z ? 16'h0004 : v + 16'h7});
		v = v + 16'h0111;
	endtask : step
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 9; a++) if (a != 6) rd(8'(4 * a), 32'h0);
		wr(OFF_CTRL2, 32'hFFFF_FFFF);
		rd(OFF_CTRL2, 32'h4F);
		foreach (tab[i]) begin
			wr(OFF_CTRL1 + 8'(4 * tab[i].ch), 32'h0);
			wr(OFF_CTRL1 + 8'(4 * tab[i].ch), {24'h0, tab[i].ctl});
			rd(OFF_CTRL1 + 8'(4 * tab[i].ch), {24'h0, tab[i].ctl & 8'h4F});
			qdec_on <= tab[i].q;
			for (int k = 0; k < tab[i].n; k++) step(tab[i].ch, tab[i].cap[k], tab[i].clr[k]);
			qdec_on <= 1'b0;
			exp_trig += tab[i].tr;
			`CHK(trig_count, exp_trig)
		end
		// Timer write lands on the capture edge with clearing enabled
		wr(OFF_CTRL3, 32'h42);
		lvl[2] = 1'b1;
		wr(OFF_TIMER, {16'h0, v});
		idle();
		tcic_pin_src_i.drive(2, 1'b1);
		wr(OFF_TIMER, 32'h0ABC);
		rd(OFF_TIMER, 32'h0ABC);
		rd(OFF_BUF3, {16'h0, v + 16'h3});
		results();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end
endmodule : tcic_capture_tb
`default_nettype wire
